// ---- rtl/epi_pkg.sv ----
package epi_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets on the plain register port)
    // ------------------------------------------------------------
    localparam logic [3:0] EPI_ADDR_SENSE = 4'h0;  // ext_irq_sense_ctrl
    localparam logic [3:0] EPI_ADDR_EN = 4'h1;     // enables: a, b, lo, mid, hi
    localparam logic [3:0] EPI_ADDR_FLAGS = 4'h2;  // pending flags, write one to clear
    localparam logic [3:0] EPI_ADDR_MASK_LO = 4'h3;
    localparam logic [3:0] EPI_ADDR_MASK_MID = 4'h4;
    localparam logic [3:0] EPI_ADDR_MASK_HI = 4'h5;
    localparam logic [3:0] EPI_ADDR_PINS = 4'h6;   // live dedicated pin levels

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int EPI_BIT_A = 0;
    localparam int EPI_BIT_B = 1;
    localparam int EPI_BIT_LO = 2;
    localparam int EPI_BIT_MID = 3;
    localparam int EPI_BIT_HI = 4;
    localparam int EPI_SENSE_A_POS = 0;
    localparam int EPI_SENSE_B_POS = 2;
    localparam logic [7:0] EPI_SENSE_RST = 8'h00;
    localparam logic [7:0] EPI_EN_RST = 8'h00;
    localparam logic [7:0] EPI_MASK_RST = 8'h00;
    localparam logic [7:0] EPI_MASK_MID_USED = 8'h7F; // line 15 does not exist
    localparam logic [7:0] EPI_SENSE_USED = 8'h0F;    // bits 7..4 read zero
    localparam logic [7:0] EPI_EN_USED = 8'h1F;

    // ------------------------------------------------------------
    // sense encoding of each dedicated pin
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EPI_SENSE_LOW = 2'h0,
        EPI_SENSE_ANY = 2'h1,
        EPI_SENSE_FALL = 2'h2,
        EPI_SENSE_RISE = 2'h3
    } epi_sense_t;

endpackage

// ---- rtl/epi_pin_detect.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// one dedicated pin: sampler and sense decode
// ------------------------------------------------------------
module epi_pin_detect
    import epi_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // pin and setting
    input wire logic pin,
    input wire logic [1:0] sense,
    input wire logic io_clk_run,
    // results
    output logic edge_event,
    output logic level_low,
    output logic pin_state
);
    logic sync1_q, sync1_d;
    logic sync2_q, sync2_d;
    logic prev_q, prev_d;
    logic rise, fall;

    // next sampler values; edges only seen while the i/o clock runs
    always_comb begin
        sync1_d = pin;
        sync2_d = sync1_q;
        prev_d = sync2_q;
        if (!io_clk_run) begin
            prev_d = prev_q; // edge memory frozen, as with a halted clock
        end
    end

    // sampler registers, idle high so reset makes no false edge
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q <= prev_d;
        end
    end

    // sense decode; only the second stage is compared
    always_comb begin
        rise = sync2_q & ~prev_q;
        fall = ~sync2_q & prev_q;
        case (epi_sense_t'(sense))
            EPI_SENSE_ANY: edge_event = io_clk_run & (rise | fall);
            EPI_SENSE_FALL: edge_event = io_clk_run & fall;
            EPI_SENSE_RISE: edge_event = io_clk_run & rise;
            default: edge_event = 1'b0;
        endcase
    end

    // low level taken straight from the pin, needs no clock
    assign level_low = (epi_sense_t'(sense) == EPI_SENSE_LOW) & ~pin;
    assign pin_state = sync2_q;

endmodule

// ---- rtl/epi_ext_irq.sv ----
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module epi_ext_irq
    import epi_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // core status
    input wire logic global_irq_en,
    input wire logic sleep_active,
    input wire logic sleep_idle,
    input wire logic startup_done,
    input wire logic irq_ack_a,
    input wire logic irq_ack_b,
    input wire logic irq_ack_lo,
    input wire logic irq_ack_mid,
    input wire logic irq_ack_hi,
    // pins, read back from the pad even when driven as outputs
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    input wire logic [23:0] pin_change_inputs,
    // requests and wake
    output logic ext_irq_a_req,
    output logic ext_irq_b_req,
    output logic pin_change_group_lo_irq,
    output logic pin_change_group_mid_irq,
    output logic pin_change_group_hi_irq,
    output logic wake_req,
    output logic io_clk_run
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ext_irq_sense_ctrl_q, ext_irq_sense_ctrl_d;
    logic [7:0] irq_enable_q, irq_enable_d;
    logic [7:0] pin_change_mask_lo_q, pin_change_mask_lo_d;
    logic [7:0] pin_change_mask_mid_q, pin_change_mask_mid_d;
    logic [7:0] pin_change_mask_hi_q, pin_change_mask_hi_d;
    logic [7:0] flags_q, flags_d;
    logic [7:0] rdata_q, rdata_d;
    logic [23:0] pc_prev_q, pc_prev_d;

    logic edge_a, edge_b, low_a, low_b, state_a, state_b;
    logic [23:0] pc_mask;
    logic [23:0] pc_toggle;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic [7:0] ack_vec;
    logic pc_async_any;
    logic level_any;

    // ------------------------------------------------------------
    // i/o clock gate
    // ------------------------------------------------------------
    // the i/o clock halts in every sleep mode but idle
    assign io_clk_run = ~sleep_active | sleep_idle;

    // ------------------------------------------------------------
    // dedicated pins
    // ------------------------------------------------------------
    epi_pin_detect u_det_a (
        .clk(clk),
        .reset_n(reset_n),
        .pin(ext_irq_pin_a),
        .sense(ext_irq_sense_ctrl_q[EPI_SENSE_A_POS +: 2]),
        .io_clk_run(io_clk_run),
        .edge_event(edge_a),
        .level_low(low_a),
        .pin_state(state_a)
    );

    epi_pin_detect u_det_b (
        .clk(clk),
        .reset_n(reset_n),
        .pin(ext_irq_pin_b),
        .sense(ext_irq_sense_ctrl_q[EPI_SENSE_B_POS +: 2]),
        .io_clk_run(io_clk_run),
        .edge_event(edge_b),
        .level_low(low_b),
        .pin_state(state_b)
    );

    // ------------------------------------------------------------
    // pin-change lines
    // ------------------------------------------------------------
    // mask vector; mid group has no line 15
    assign pc_mask = {pin_change_mask_hi_q,
                      pin_change_mask_mid_q & EPI_MASK_MID_USED,
                      pin_change_mask_lo_q};

    // per-line toggle against the last seen level
    genvar gi;
    generate
        for (gi = 0; gi < 24; gi++) begin : g_pc
            assign pc_toggle[gi] = pc_mask[gi] & (pin_change_inputs[gi] ^ pc_prev_q[gi]);
        end
    endgenerate

    // combinational compare needs no clock, so it can wake from any sleep
    assign pc_async_any = |pc_toggle;

    // low level held: wake without clock, interrupt only if it lasts
    assign level_any = (low_a & irq_enable_q[EPI_BIT_A]) | (low_b & irq_enable_q[EPI_BIT_B]);
    assign wake_req = pc_async_any | level_any;

    // ------------------------------------------------------------
    // pending flags
    // ------------------------------------------------------------
    // event collection; also true for pins we drive ourselves
    always_comb begin
        set_vec = 8'h00;
        set_vec[EPI_BIT_A] = edge_a;
        set_vec[EPI_BIT_B] = edge_b;
        set_vec[EPI_BIT_LO] = |pc_toggle[7:0];
        set_vec[EPI_BIT_MID] = |pc_toggle[14:8];
        set_vec[EPI_BIT_HI] = |pc_toggle[23:16];
        ack_vec = 8'h00;
        ack_vec[EPI_BIT_A] = irq_ack_a;
        ack_vec[EPI_BIT_B] = irq_ack_b;
        ack_vec[EPI_BIT_LO] = irq_ack_lo;
        ack_vec[EPI_BIT_MID] = irq_ack_mid;
        ack_vec[EPI_BIT_HI] = irq_ack_hi;
        clr_vec = ack_vec;
        if (reg_wr && reg_addr == EPI_ADDR_FLAGS) begin
            clr_vec = ack_vec | reg_wdata;
        end
        // set wins over a clear in the same cycle
        flags_d = ((flags_q & ~clr_vec) | set_vec) & EPI_EN_USED;
        // toggles are consumed once a clock runs to register them
        pc_prev_d = pin_change_inputs;
    end

    // flag and history registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flags_q <= 8'h00;
            pc_prev_q <= 24'h000000;
        end else begin
            flags_q <= flags_d;
            pc_prev_q <= pc_prev_d;
        end
    end

    // ------------------------------------------------------------
    // requests
    // ------------------------------------------------------------
    // level mode requests as long as the pin stays low; a level gone before
    // start-up ends leaves only the wake, since low_x has dropped by then
    always_comb begin
        ext_irq_a_req = global_irq_en & irq_enable_q[EPI_BIT_A] &
                        (flags_q[EPI_BIT_A] | (low_a & startup_done));
        ext_irq_b_req = global_irq_en & irq_enable_q[EPI_BIT_B] &
                        (flags_q[EPI_BIT_B] | (low_b & startup_done));
        pin_change_group_lo_irq = global_irq_en & irq_enable_q[EPI_BIT_LO] & flags_q[EPI_BIT_LO];
        pin_change_group_mid_irq = global_irq_en & irq_enable_q[EPI_BIT_MID] &
                                   flags_q[EPI_BIT_MID];
        pin_change_group_hi_irq = global_irq_en & irq_enable_q[EPI_BIT_HI] & flags_q[EPI_BIT_HI];
    end

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    // writes and read mux
    always_comb begin
        ext_irq_sense_ctrl_d = ext_irq_sense_ctrl_q;
        irq_enable_d = irq_enable_q;
        pin_change_mask_lo_d = pin_change_mask_lo_q;
        pin_change_mask_mid_d = pin_change_mask_mid_q;
        pin_change_mask_hi_d = pin_change_mask_hi_q;
        if (reg_wr) begin
            case (reg_addr)
                EPI_ADDR_SENSE: ext_irq_sense_ctrl_d = reg_wdata & EPI_SENSE_USED;
                EPI_ADDR_EN: irq_enable_d = reg_wdata & EPI_EN_USED;
                EPI_ADDR_MASK_LO: pin_change_mask_lo_d = reg_wdata;
                EPI_ADDR_MASK_MID: pin_change_mask_mid_d = reg_wdata & EPI_MASK_MID_USED;
                EPI_ADDR_MASK_HI: pin_change_mask_hi_d = reg_wdata;
                default: ;
            endcase
        end
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                EPI_ADDR_SENSE: rdata_d = ext_irq_sense_ctrl_q;
                EPI_ADDR_EN: rdata_d = irq_enable_q;
                EPI_ADDR_FLAGS: rdata_d = flags_q;
                EPI_ADDR_MASK_LO: rdata_d = pin_change_mask_lo_q;
                EPI_ADDR_MASK_MID: rdata_d = pin_change_mask_mid_q;
                EPI_ADDR_MASK_HI: rdata_d = pin_change_mask_hi_q;
                EPI_ADDR_PINS: rdata_d = {6'h00, state_b, state_a};
                default: rdata_d = 8'h00; // unmapped reads zero
            endcase
        end
    end

    // register storage
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ext_irq_sense_ctrl_q <= EPI_SENSE_RST;
            irq_enable_q <= EPI_EN_RST;
            pin_change_mask_lo_q <= EPI_MASK_RST;
            pin_change_mask_mid_q <= EPI_MASK_RST;
            pin_change_mask_hi_q <= EPI_MASK_RST;
            rdata_q <= 8'h00;
        end else begin
            ext_irq_sense_ctrl_q <= ext_irq_sense_ctrl_d;
            irq_enable_q <= irq_enable_d;
            pin_change_mask_lo_q <= pin_change_mask_lo_d;
            pin_change_mask_mid_q <= pin_change_mask_mid_d;
            pin_change_mask_hi_q <= pin_change_mask_hi_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

endmodule

// ---- verif/epi_ext_irq_props.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// port checker of the interrupt block
// ----------------------------------------
module epi_ext_irq_props
    import epi_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port and core status
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic global_irq_en,
    input wire logic sleep_active,
    input wire logic sleep_idle,
    input wire logic startup_done,
    // pins and requests
    input wire logic ext_irq_pin_a,
    input wire logic ext_irq_pin_b,
    input wire logic [23:0] pin_change_inputs,
    input wire logic ext_irq_a_req,
    input wire logic ext_irq_b_req,
    input wire logic pin_change_group_lo_irq,
    input wire logic wake_req,
    input wire logic io_clk_run
);
    // shadow of the sense, enable and low mask registers, so properties know the mode
    logic [7:0] sense_q, sense_d, en_q, en_d, mask_q, mask_d;

    always_comb begin
        sense_d = (reg_wr && reg_addr == EPI_ADDR_SENSE) ? reg_wdata : sense_q;
        en_d = (reg_wr && reg_addr == EPI_ADDR_EN) ? reg_wdata : en_q;
        mask_d = (reg_wr && reg_addr == EPI_ADDR_MASK_LO) ? reg_wdata : mask_q;
    end

    // shadow updates on the same edge as the block's own registers
    always_ff @(posedge clk) begin
        sense_q <= reset_n ? sense_d : EPI_SENSE_RST;
        en_q <= reset_n ? en_d : EPI_EN_RST;
        mask_q <= reset_n ? mask_d : EPI_MASK_RST;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    io_clock_gate_a: assert property (
        io_clk_run == !(sleep_active && !sleep_idle)) else $error("io clock gate wrong");
    level_req_a: assert property (
        (sense_q[3:2] == 2'h0 && en_q[EPI_BIT_B] && global_irq_en && startup_done
        && !ext_irq_pin_b) |-> ext_irq_b_req) else $error("level request missing");
    level_wake_a: assert property (
        (sense_q[3:2] == 2'h0 && en_q[EPI_BIT_B] && !ext_irq_pin_b) |-> wake_req)
        else $error("level wake missing");
    global_gate_a: assert property (
        !global_irq_en |-> !ext_irq_a_req && !ext_irq_b_req) else $error("request without global");
    enable_gate_a: assert property (
        !en_q[EPI_BIT_A] |-> !ext_irq_a_req) else $error("request while disabled");
    fall_edge_a: assert property (
        ($fell(ext_irq_pin_a) && sense_q[1:0] == EPI_SENSE_FALL && en_q[EPI_BIT_A]
        && global_irq_en && io_clk_run) |-> ##[1:4] ext_irq_a_req) else $error("fall missed");
    group_lo_a: assert property (
        (|((pin_change_inputs[7:0] ^ $past(pin_change_inputs[7:0])) & mask_q)
        && en_q[EPI_BIT_LO] && global_irq_en) |-> ##[0:3] pin_change_group_lo_irq)
        else $error("low group change missed");
    pc_wake_a: assert property (
        |((pin_change_inputs[7:0] ^ $past(pin_change_inputs[7:0])) & mask_q) |-> wake_req)
        else $error("pin change wake missing");
    mask_read_a: assert property (
        $past(reg_rd && reg_addr == EPI_ADDR_MASK_LO) |-> reg_rdata == mask_q)
        else $error("mask read back wrong");

    // main scenarios seen
    cover property (ext_irq_a_req);
    cover property (ext_irq_b_req && wake_req);
    cover property (pin_change_group_lo_irq && !io_clk_run);
endmodule

bind epi_ext_irq epi_ext_irq_props epi_ext_irq_props_i (
    .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .global_irq_en,
    .sleep_active, .sleep_idle, .startup_done, .ext_irq_pin_a, .ext_irq_pin_b,
    .pin_change_inputs, .ext_irq_a_req, .ext_irq_b_req, .pin_change_group_lo_irq,
    .wake_req, .io_clk_run
);

// ---- verif/epi_pin_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// outside circuitry on the interrupt pins
// ----------------------------------------
module epi_pin_model (
    // clock
    input wire logic clk,
    // pins
    output logic pin_a,
    output logic pin_b,
    output logic [23:0] pc_lines
);
    // dedicated pins idle high as if pulled up
    initial begin
        pin_a = 1'b1;
        pin_b = 1'b1;
        pc_lines = 24'h000000;
    end

    // each level is held well past one clock and past start-up
    task automatic drive(input logic a, input logic b, input logic [23:0] pc);
        @(posedge clk);
        pin_a <= a;
        pin_b <= b;
        pc_lines <= pc;
        repeat (5) @(posedge clk);
    endtask
endmodule

// ---- verif/epi_ext_irq_tb.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// bench of the interrupt block
// ----------------------------------------
module epi_ext_irq_tb;
    import epi_pkg::*;
    logic clk, reset_n, reg_wr, reg_rd, global_irq_en, sleep_active, sleep_idle, startup_done;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, grp;
    logic [4:0] ack;
    logic pin_a, pin_b, ext_irq_a_req, ext_irq_b_req, wake_req, io_clk_run;
    logic pin_change_group_lo_irq, pin_change_group_mid_irq, pin_change_group_hi_irq;
    logic [23:0] pc_lines;
    int error_cnt = 0;
    int checks = 0;
    // toggled line and expected {hi, mid, lo}; line 15 does not exist
    int pc_line[6] = '{0, 3, 14, 15, 22, 23};
    logic [7:0] pc_grp[6] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h04};
    assign grp = {5'h00, pin_change_group_hi_irq, pin_change_group_mid_irq,
        pin_change_group_lo_irq};

    epi_ext_irq epi_ext_irq_i (
        .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .global_irq_en,
        .sleep_active, .sleep_idle, .startup_done, .irq_ack_a(ack[0]), .irq_ack_b(ack[1]),
        .irq_ack_lo(ack[2]), .irq_ack_mid(ack[3]), .irq_ack_hi(ack[4]),
        .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b), .pin_change_inputs(pc_lines),
        .ext_irq_a_req, .ext_irq_b_req, .pin_change_group_lo_irq, .pin_change_group_mid_irq,
        .pin_change_group_hi_irq, .wake_req, .io_clk_run
    );
    epi_pin_model epi_pin_model_i (.clk, .pin_a, .pin_b, .pc_lines);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // compare tasks, one per kind of result
    task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk1(input string nm, input logic exp, input logic got);
        chk8(nm, {7'h00, exp}, {7'h00, got});
    endtask

    // register port cycles, one strobe cycle each
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk8("read data", exp, reg_rdata);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog: the run needs a few hundred cycles at most
    initial begin
        #100000;
        error_cnt++;
        end_of_test();
    end

    initial begin
        {reset_n, reg_wr, reg_rd, sleep_active, sleep_idle, ack} = '0;
        {reg_addr, reg_wdata, global_irq_en, startup_done} = {12'h000, 2'b11};
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 6; a++) rd(4'(a), 8'h00);
        rd(EPI_ADDR_PINS, 8'h03);
        rd(4'hF, 8'h00);
        wr(EPI_ADDR_SENSE, 8'hFF);
        rd(EPI_ADDR_SENSE, EPI_SENSE_USED);
        wr(EPI_ADDR_MASK_MID, 8'hFF);
        rd(EPI_ADDR_MASK_MID, EPI_MASK_MID_USED);
        wr(EPI_ADDR_EN, 8'hFF);
        rd(EPI_ADDR_EN, EPI_EN_USED);
        // any, falling and rising sense on pin a, ack between edges
        for (int m = 1; m < 4; m++) begin
            wr(EPI_ADDR_SENSE, 8'(m));
            wr(EPI_ADDR_FLAGS, 8'h1F);
            epi_pin_model_i.drive(1'b0, 1'b1, 24'h000000);
            #1;
            chk1("request a on fall", m != 3, ext_irq_a_req);
            @(posedge clk);
            ack[0] <= 1'b1;
            @(posedge clk);
            ack[0] <= 1'b0;
            rd(EPI_ADDR_FLAGS, 8'h00);
            epi_pin_model_i.drive(1'b1, 1'b1, 24'h000000);
            #1;
            chk1("request a on rise", m != 2, ext_irq_a_req);
        end
        // deep sleep: no edge flag while asleep, pin changes still caught
        wr(EPI_ADDR_SENSE, 8'h02);
        wr(EPI_ADDR_MASK_LO, 8'h08);
        rd(EPI_ADDR_MASK_LO, 8'h08);
        wr(EPI_ADDR_MASK_MID, 8'h40);
        wr(EPI_ADDR_MASK_HI, 8'h80);
        wr(EPI_ADDR_FLAGS, 8'h1F);
        sleep_active <= 1'b1;
        sleep_idle <= 1'b1;
        @(posedge clk);
        #1;
        chk1("io clock in idle", 1'b1, io_clk_run);
        @(posedge clk);
        sleep_idle <= 1'b0;
        @(posedge clk);
        #1;
        chk1("io clock run", 1'b0, io_clk_run);
        epi_pin_model_i.drive(1'b0, 1'b1, 24'h000008);
        rd(EPI_ADDR_FLAGS, 8'h04);
        @(posedge clk);
        sleep_active <= 1'b0;
        // one line at a time against the group masks
        for (int i = 0; i < 6; i++) begin
            wr(EPI_ADDR_FLAGS, 8'h1F);
            epi_pin_model_i.drive(1'b1, 1'b1, pc_lines ^ (24'h000001 << pc_line[i]));
            #1;
            chk8("group requests", pc_grp[i], grp);
        end
        // service pulse clears the pending high group flag
        rd(EPI_ADDR_FLAGS, 8'h10);
        @(posedge clk);
        ack <= 5'h10;
        @(posedge clk);
        ack <= 5'h00;
        rd(EPI_ADDR_FLAGS, 8'h00);
        // low level on pin b
        wr(EPI_ADDR_SENSE, 8'h00);
        epi_pin_model_i.drive(1'b1, 1'b0, pc_lines);
        #1;
        chk1("level request b", 1'b1, ext_irq_b_req);
        chk1("wake on level", 1'b1, wake_req);
        rd(EPI_ADDR_PINS, 8'h01);
        @(posedge clk);
        startup_done <= 1'b0;
        @(posedge clk);
        #1;
        chk1("request before start-up", 1'b0, ext_irq_b_req);
        @(posedge clk);
        startup_done <= 1'b1;
        global_irq_en <= 1'b0;
        @(posedge clk);
        #1;
        chk1("request without global", 1'b0, ext_irq_b_req);
        @(posedge clk);
        global_irq_en <= 1'b1;
        epi_pin_model_i.drive(1'b1, 1'b1, pc_lines);
        #1;
        chk1("level released", 1'b0, ext_irq_b_req);
        end_of_test();
    end
endmodule
